// ==== hdl/ptc_core.v ====
// pixel tone correction: apb registers, correction pipeline, tables, output fifo
//
// Implementation choices: the register addresses and the APB register port.

`include "ptc_regs.vh"

// ****************************************
// output fifo
// ****************************************
module ptc_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [31:0] DEPTH_W = DEPTH;
  localparam [31:0] LAST_W = DEPTH - 1;
  localparam [AW:0] FULL = DEPTH_W[AW:0];
  localparam [AW-1:0] LAST = LAST_W[AW-1:0];
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = cnt_r != FULL;
  assign out_valid = cnt_r != {(AW+1){1'b0}};
  assign out_data = mem[rd_r];
  always @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= (wr_r == LAST) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == LAST) ? {AW{1'b0}} : rd_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ****************************************
// correction core
// ****************************************
module ptc_core (
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire pix_in_valid,
  output wire pix_in_ready,
  input wire [11:0] pix_in_level,
  input wire [1:0] pix_in_colour,
  input wire pix_in_last,
  output wire pix_out_valid,
  input wire pix_out_ready,
  output wire [9:0] pix_out_level,
  output wire [1:0] pix_out_colour,
  output wire pix_out_last
);
  localparam [1:0] W_IDLE = 2'b00;
  localparam [1:0] W_GEN = 2'b01;
  localparam [1:0] W_STORE = 2'b10;
  localparam [1:0] W_RECALL = 2'b11;

  function [1:0] ch_of;
    input [1:0] c;
    begin
      ch_of = (c == 2'h3) ? `PTC_CH_GREEN : c;
    end
  endfunction

  function [11:0] clip12;
    input [23:0] v;
    begin
      clip12 = (v[23:8] > {4'h0, `PTC_PIX_MAX}) ? `PTC_PIX_MAX : v[19:8];
    end
  endfunction

  function [9:0] clip10;
    input [31:0] v;
    begin
      clip10 = (v > {22'h0, `PTC_LEVEL_MAX}) ? `PTC_LEVEL_MAX : v[9:0];
    end
  endfunction

  // quadratic bend of the identity line, strength from gamma
  function [9:0] gamma_pt;
    input [9:0] x;
    input [11:0] g;
    integer xi;
    integer gi;
    integer d;
    integer y;
    begin
      // signed arithmetic, so gamma below 1.0 bends the line downward
      xi = x;
      gi = g;
      d = (xi * (1023 - xi)) / 1024;
      y = xi + ((d * (gi - 256)) / 256);
      if (y < 0) begin
        y = 0;
      end
      gamma_pt = clip10(y);
    end
  endfunction

  integer i;
  // ****************************************
  // registers
  // ****************************************
  reg [1:0] gain_pick_r;
  reg [11:0] gain_r [0:2];
  reg signed [13:0] dark_r;
  reg [1:0] awb_mode_r;
  reg [1:0] wb_pick_r;
  reg [10:0] wb_r [0:2];
  reg [11:0] gamma_r;
  reg gamma_act_r;
  reg tbl_pick_r;
  reg [1:0] tbl_on_r;
  reg [9:0] ptr_r;
  reg [31:0] prdata_r;
  reg err_r;
  reg [9:0] tbl0 [0:1023];
  reg [9:0] tbl1 [0:1023];
  reg [9:0] nvm [0:2047];
  reg [1:0] wst_r;
  reg [9:0] wadr_r;
  reg wtbl_r;
  reg [31:0] acc_r [0:2];
  reg [6:0] frames_r;

  wire wr = psel & penable & pwrite;
  wire setup = psel & ~penable;
  wire wbusy = wst_r != W_IDLE;
  wire [31:0] wd = pwdata;
  wire [9:0] wd_lvl = clip10(wd);
  wire [9:0] pick_lvl = tbl_pick_r ? tbl1[ptr_r] : tbl0[ptr_r];
  wire f_ready;
  wire fifo_full = ~f_ready;

  // ****************************************
  // apb slave
  // ****************************************
  reg [31:0] rmux;
  reg hit;
  always @* begin
    rmux = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      `PTC_A_GAIN_PICK: rmux[1:0] = gain_pick_r;
      `PTC_A_GAIN: rmux[11:0] = gain_r[gain_pick_r];
      `PTC_A_DARK: rmux = {{18{dark_r[13]}}, dark_r};
      `PTC_A_AWB_MODE: rmux[1:0] = awb_mode_r;
      `PTC_A_WB_PICK: rmux[1:0] = wb_pick_r;
      `PTC_A_WB_FACTOR: rmux[10:0] = wb_r[wb_pick_r];
      `PTC_A_GAMMA: rmux[11:0] = gamma_r;
      `PTC_A_TBL_PICK: rmux[0] = tbl_pick_r;
      `PTC_A_TBL_ON: rmux[0] = tbl_on_r[tbl_pick_r];
      `PTC_A_TBL_PTR: rmux[9:0] = ptr_r;
      `PTC_A_TBL_LEVEL: rmux[9:0] = pick_lvl;
      `PTC_A_TBL_STORE: rmux = 32'h0000_0000;
      `PTC_A_TBL_RECALL: rmux = 32'h0000_0000;
      `PTC_A_STATUS: rmux[3:0] = {fifo_full, gamma_act_r, awb_mode_r == `PTC_AWB_ONCE, wbusy};
      default: hit = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = psel & penable & err_r;

  // ****************************************
  // pixel pipeline
  // ****************************************
  reg p1_v, p2_v, p3_v, p4_v;
  reg [11:0] p1_d, p2_d, p3_d;
  reg [9:0] p4_d;
  reg [1:0] p1_c, p2_c, p3_c, p4_c;
  reg p1_l, p2_l, p3_l, p4_l;
  wire adv = ~p4_v | f_ready;
  wire frame_end = adv & p3_v & p3_l;
  wire signed [14:0] off_sum = $signed({3'b000, pix_in_level}) + dark_r;
  wire [23:0] g_prod = p1_d * gain_r[p1_c];
  wire [22:0] w_prod = p2_d * wb_r[p2_c];
  assign pix_in_ready = adv;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      {p1_v, p2_v, p3_v, p4_v} <= 4'h0;
      {p1_l, p2_l, p3_l, p4_l} <= 4'h0;
      {p1_d, p2_d, p3_d} <= 36'h0_0000_0000;
      p4_d <= 10'h000;
      {p1_c, p2_c, p3_c, p4_c} <= 8'h00;
    end else if (adv) begin
      // offset, gain, ratio, table: one pixel per stage, no reordering
      p1_v <= pix_in_valid;
      p1_c <= ch_of(pix_in_colour);
      p1_l <= pix_in_last;
      p1_d <= off_sum[14] ? 12'h000 : (off_sum[13:12] != 2'b00) ? `PTC_PIX_MAX : off_sum[11:0];
      p2_v <= p1_v;
      p2_c <= p1_c;
      p2_l <= p1_l;
      p2_d <= clip12(g_prod);
      p3_v <= p2_v;
      p3_c <= p2_c;
      p3_l <= p2_l;
      p3_d <= clip12({1'b0, w_prod});
      p4_v <= p3_v;
      p4_c <= p3_c;
      p4_l <= p3_l;
      // 12-bit level indexes the table by its upper 10 bits
      if (tbl_on_r[0]) begin
        p4_d <= tbl0[p3_d[11:2]];
      end else if (tbl_on_r[1]) begin
        p4_d <= tbl1[p3_d[11:2]];
      end else if (gamma_act_r) begin
        p4_d <= tbl0[p3_d[11:2]];
      end else begin
        p4_d <= p3_d[11:2];
      end
    end
  end

  ptc_fifo #(.WIDTH(13), .DEPTH(8), .AW(3)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(p4_v),
    .in_ready(f_ready),
    .in_data({p4_l, p4_c, p4_d}),
    .out_valid(pix_out_valid),
    .out_ready(pix_out_ready),
    .out_data({pix_out_last, pix_out_colour, pix_out_level})
  );

  // ****************************************
  // table walker: gamma fill, store, recall
  // ****************************************
  reg t0_we, t1_we;
  reg [9:0] t0_wa, t1_wa, t0_wd, t1_wd;
  wire [9:0] walk_src = wtbl_r ? tbl1[wadr_r] : tbl0[wadr_r];
  wire [9:0] nvm_val = nvm[{wtbl_r, wadr_r}];
  wire apb_lvl_wr = wr & (paddr == `PTC_A_TBL_LEVEL) & ~wbusy;
  always @* begin
    t0_we = 1'b0;
    t1_we = 1'b0;
    t0_wa = ptr_r;
    t1_wa = ptr_r;
    t0_wd = wd_lvl;
    t1_wd = wd_lvl;
    if (wst_r == W_GEN) begin
      t0_we = 1'b1;
      t0_wa = wadr_r;
      t0_wd = gamma_pt(wadr_r, gamma_r);
    end else if (wst_r == W_RECALL) begin
      t0_we = ~wtbl_r;
      t1_we = wtbl_r;
      t0_wa = wadr_r;
      t1_wa = wadr_r;
      t0_wd = nvm_val;
      t1_wd = nvm_val;
    end else if (apb_lvl_wr) begin
      t0_we = ~tbl_pick_r;
      t1_we = tbl_pick_r;
    end
  end
  always @(posedge clk) begin
    if (t0_we) begin
      tbl0[t0_wa] <= t0_wd;
    end
    if (t1_we) begin
      tbl1[t1_wa] <= t1_wd;
    end
    if (wst_r == W_STORE) begin
      nvm[{wtbl_r, wadr_r}] <= walk_src;
    end
  end

  // ****************************************
  // control state
  // ****************************************
  wire awb_start = wr & (paddr == `PTC_A_AWB_MODE);
  wire gam_wr = wr & (paddr == `PTC_A_GAMMA) & ~wbusy & (tbl_on_r == 2'b00);
  wire [11:0] gam_val = (wd > {20'h0, `PTC_GAMMA_MAX}) ? `PTC_GAMMA_MAX :
    (wd < {20'h0, `PTC_GAMMA_MIN}) ? `PTC_GAMMA_MIN : wd[11:0];
  wire [31:0] tol = acc_r[1] >> `PTC_AWB_TOL_SH;
  // red and blue sums within tolerance of green
  wire [1:0] adj_ok;
  assign adj_ok[0] = (acc_r[0] + tol >= acc_r[1]) & (acc_r[0] <= acc_r[1] + tol);
  assign adj_ok[1] = (acc_r[2] + tol >= acc_r[1]) & (acc_r[2] <= acc_r[1] + tol);
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      gain_pick_r <= `PTC_CH_RED;
      dark_r <= `PTC_DARK_RST;
      awb_mode_r <= `PTC_AWB_OFF;
      wb_pick_r <= `PTC_CH_RED;
      gamma_r <= `PTC_GAMMA_RST;
      gamma_act_r <= 1'b0;
      tbl_pick_r <= 1'b0;
      tbl_on_r <= 2'b00;
      ptr_r <= 10'h000;
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
      wst_r <= W_IDLE;
      wadr_r <= 10'h000;
      wtbl_r <= 1'b0;
      frames_r <= 7'h00;
      for (i = 0; i < 3; i = i + 1) begin
        gain_r[i] <= `PTC_GAIN_RST;
        wb_r[i] <= `PTC_WB_RST;
        acc_r[i] <= 32'h0000_0000;
      end
    end else begin
      if (setup) begin
        prdata_r <= rmux;
        err_r <= ~hit;
      end
      // per-colour sums of the balanced pixels of a frame before its last pixel
      for (i = 0; i < 3; i = i + 1) begin
        if (frame_end) begin
          acc_r[i] <= 32'h0000_0000;
        end else if (adv & p3_v & (p3_c == i)) begin
          acc_r[i] <= acc_r[i] + p3_d;
        end
      end
      if (frame_end & (awb_mode_r == `PTC_AWB_ONCE)) begin
        // nudge red and blue toward green, one step per frame
        for (i = 0; i < 3; i = i + 2) begin
          if (acc_r[i] + tol < acc_r[1]) begin
            if (wb_r[i] < `PTC_WB_MAX) begin
              wb_r[i] <= wb_r[i] + `PTC_AWB_STEP;
            end
          end else if (acc_r[i] > acc_r[1] + tol) begin
            if (wb_r[i] > `PTC_WB_MIN + `PTC_AWB_STEP) begin
              wb_r[i] <= wb_r[i] - `PTC_AWB_STEP;
            end
          end
        end
        frames_r <= frames_r + 1'b1;
        if ((adj_ok == 2'b11) | (frames_r == `PTC_AWB_MAX_FRAMES)) begin
          awb_mode_r <= `PTC_AWB_OFF;
        end
      end
      if (awb_start) begin
        frames_r <= 7'h00;
        if (pwdata[1:0] == `PTC_AWB_RESET) begin
          awb_mode_r <= `PTC_AWB_OFF;
          for (i = 0; i < 3; i = i + 1) begin
            wb_r[i] <= `PTC_WB_RST;
          end
        end else if (pwdata[1:0] != 2'h3) begin
          awb_mode_r <= pwdata[1:0];
        end
      end
      if (wr) begin
        case (paddr)
          `PTC_A_GAIN_PICK: if (pwdata[1:0] != 2'h3) gain_pick_r <= pwdata[1:0];
          `PTC_A_GAIN: gain_r[gain_pick_r] <= (wd > {20'h0, `PTC_GAIN_MAX}) ?
            `PTC_GAIN_MAX : wd[11:0];
          `PTC_A_DARK: dark_r <= ($signed(wd) > `PTC_DARK_MAX) ? `PTC_DARK_MAX :
            ($signed(wd) < `PTC_DARK_MIN) ? `PTC_DARK_MIN : wd[13:0];
          `PTC_A_WB_PICK: if (pwdata[1:0] != 2'h3) wb_pick_r <= pwdata[1:0];
          `PTC_A_WB_FACTOR: wb_r[wb_pick_r] <= (wd > {21'h0, `PTC_WB_MAX}) ? `PTC_WB_MAX :
            (wd < {21'h0, `PTC_WB_MIN}) ? `PTC_WB_MIN : wd[10:0];
          `PTC_A_TBL_PICK: tbl_pick_r <= pwdata[0];
          `PTC_A_TBL_ON: tbl_on_r[tbl_pick_r] <= pwdata[0];
          `PTC_A_TBL_PTR: ptr_r <= wd_lvl;
          default: ;
        endcase
      end
      case (wst_r)
        W_IDLE: begin
          wadr_r <= 10'h000;
          wtbl_r <= tbl_pick_r;
          if (gam_wr) begin
            gamma_r <= gam_val;
            gamma_act_r <= gam_val != `PTC_GAMMA_RST;
            wst_r <= W_GEN;
          end else if (wr & (paddr == `PTC_A_TBL_STORE) & pwdata[0]) begin
            wst_r <= W_STORE;
          end else if (wr & (paddr == `PTC_A_TBL_RECALL) & pwdata[0]) begin
            wst_r <= W_RECALL;
          end
        end
        W_GEN, W_STORE, W_RECALL: begin
          wadr_r <= wadr_r + 1'b1;
          if (wadr_r == `PTC_LEVEL_MAX) begin
            wst_r <= W_IDLE;
          end
        end
        default: wst_r <= W_IDLE;
      endcase
      // a hand-programmed entry in table 0 ends the gamma curve
      if (apb_lvl_wr & ~tbl_pick_r) begin
        gamma_act_r <= 1'b0;
      end
    end
  end
endmodule

// ==== pkg/ptc_regs.vh ====
// register map, reset values and constants of the pixel tone correction block
`ifndef PTC_REGS_VH
`define PTC_REGS_VH
`define PTC_A_GAIN_PICK 8'h00
`define PTC_A_GAIN 8'h04
`define PTC_A_DARK 8'h08
`define PTC_A_AWB_MODE 8'h0C
`define PTC_A_WB_PICK 8'h10
`define PTC_A_WB_FACTOR 8'h14
`define PTC_A_GAMMA 8'h18
`define PTC_A_TBL_PICK 8'h1C
`define PTC_A_TBL_ON 8'h20
`define PTC_A_TBL_PTR 8'h24
`define PTC_A_TBL_LEVEL 8'h28
`define PTC_A_TBL_STORE 8'h2C
`define PTC_A_TBL_RECALL 8'h30
`define PTC_A_STATUS 8'h34
`define PTC_GAIN_MAX 12'h0800
`define PTC_GAIN_RST 12'h0100
`define PTC_DARK_MAX 14'sh1000
`define PTC_DARK_MIN -14'sh1000
`define PTC_DARK_RST 14'h0000
`define PTC_WB_MIN 11'h01A
`define PTC_WB_MAX 11'h400
`define PTC_WB_RST 11'h100
`define PTC_GAMMA_MIN 12'h001A
`define PTC_GAMMA_MAX 12'h0A00
`define PTC_GAMMA_RST 12'h0100
`define PTC_LEVEL_MAX 10'h3FF
`define PTC_PIX_MAX 12'hFFF
`define PTC_AWB_OFF 2'h0
`define PTC_AWB_ONCE 2'h1
`define PTC_AWB_RESET 2'h2
`define PTC_AWB_STEP 11'h004
`define PTC_AWB_TOL_SH 5
`define PTC_AWB_MAX_FRAMES 7'h40
`define PTC_CH_RED 2'h0
`define PTC_CH_GREEN 2'h1
`define PTC_CH_BLUE 2'h2
`endif

// ==== verification/ptc_core_props.sv ====
// port checker of the tone correction core
`include "ptc_regs.vh"
module ptc_core_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic pix_in_valid,
  input wire logic pix_in_ready,
  input wire logic pix_out_valid,
  input wire logic pix_out_ready,
  input wire logic [9:0] pix_out_level,
  input wire logic pix_out_last
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // apb and stream checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire rd = psel && penable && !pwrite;
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("error flag outside access");
  property p_unmapped; rd && paddr > 8'h34 |-> pslverr && prdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_ptr; rd && paddr == `PTC_A_TBL_PTR |-> prdata[31:10] == 22'h0; endproperty
  a_ptr: assert property (p_ptr) else $error("pointer out of range");
  property p_awb; rd && paddr == `PTC_A_AWB_MODE |-> prdata < 32'h0000_0002; endproperty
  a_awb: assert property (p_awb) else $error("balance mode reads reset");
  property p_gain; rd && paddr == `PTC_A_GAIN |-> prdata <= 32'h0000_0800; endproperty
  a_gain: assert property (p_gain) else $error("gain above maximum");
  property p_hold;
    pix_out_valid && !pix_out_ready |=>
      pix_out_valid && $stable(pix_out_level) && $stable(pix_out_last);
  endproperty
  a_hold: assert property (p_hold) else $error("output pixel changed while held");
  property p_lat; $rose(pix_out_valid) |-> $past(pix_in_valid && pix_in_ready, 5); endproperty
  a_lat: assert property (p_lat) else $error("pixel latency wrong");
  property p_refuse; !pix_in_ready |-> pix_out_valid; endproperty
  a_refuse: assert property (p_refuse) else $error("input refused with empty output");
  c_stall: cover property (!pix_in_ready);
  c_err: cover property (pslverr);
  c_last: cover property (pix_out_valid && pix_out_ready && pix_out_last);
endmodule

// ==== verification/ptc_core_test.sv ====
// self-checking bench of the tone correction core
`include "ptc_regs.vh"
module ptc_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals, instances, bus tasks
  // ****************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic stall = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  wire [31:0] prdata;
  wire pready, pslverr, pix_in_valid, pix_in_ready, pix_in_last;
  wire pix_out_valid, pix_out_ready, pix_out_last;
  wire [11:0] pix_in_level;
  wire [9:0] pix_out_level;
  wire [1:0] pix_in_colour, pix_out_colour;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  ptc_core i_dut (.*);
  ptc_far_side i_far (.*);
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
  endtask
  task automatic wait_idle;
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, `PTC_A_STATUS, 32'h0000_0000, r, e);
      n++;
    end while (r[0] !== 1'b0 && n < 1000);
    chk({31'h0000_0000, r[0]}, 32'h0000_0000);
  endtask
  function automatic int cl(input int v);
    return v < 0 ? 0 : (v > 4095 ? 4095 : v);
  endfunction
  function automatic logic [9:0] lvl(input int l, input int d, input int g, input int w);
    return 10'(cl(cl(cl(l + d) * g >> 8) * w >> 8) >> 2);
  endfunction
  task automatic send(input logic [11:0] l, input logic [1:0] c, input logic last);
    i_far.src_q.push_back({last, c, l});
  endtask
  task automatic drain(input int n);
    int k;
    k = 0;
    while (i_far.got_q.size() < n && k < 2000) begin
      @(posedge clk);
      k++;
    end
    chk(i_far.got_q.size(), n);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rd(`PTC_A_GAIN, 32'h0000_0100);
    rd(`PTC_A_DARK, 32'h0000_0000);
    rd(`PTC_A_AWB_MODE, 32'h0000_0000);
    rd(`PTC_A_WB_PICK, 32'h0000_0000);
    rd(`PTC_A_WB_FACTOR, 32'h0000_0100);
    rd(`PTC_A_GAMMA, 32'h0000_0100);
    rd(`PTC_A_TBL_ON, 32'h0000_0000);
    wr(`PTC_A_GAIN, 32'h0000_0FFF);
    rd(`PTC_A_GAIN, 32'h0000_0800);
    wr(`PTC_A_DARK, 32'hFFFF_0000);
    rd(`PTC_A_DARK, 32'hFFFF_F000);
    wr(`PTC_A_WB_FACTOR, 32'h0000_0000);
    rd(`PTC_A_WB_FACTOR, 32'h0000_001A);
    apb(1'b0, 8'h40, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0000);
    chk(e, 1'b1);
    $display("end of register test");
  endtask
  task automatic t_pick;
    wr(`PTC_A_GAIN_PICK, 32'h0000_0001);
    rd(`PTC_A_GAIN, 32'h0000_0100);
    wr(`PTC_A_GAIN, 32'h0000_0200);
    wr(`PTC_A_GAIN_PICK, 32'h0000_0000);
    rd(`PTC_A_GAIN, 32'h0000_0800);
    wr(`PTC_A_WB_PICK, 32'h0000_0002);
    rd(`PTC_A_WB_FACTOR, 32'h0000_0100);
    wr(`PTC_A_WB_FACTOR, 32'h0000_0500);
    rd(`PTC_A_WB_FACTOR, 32'h0000_0400);
    wr(`PTC_A_AWB_MODE, 32'h0000_0002);
    rd(`PTC_A_AWB_MODE, 32'h0000_0000);
    rd(`PTC_A_WB_FACTOR, 32'h0000_0100);
    wr(`PTC_A_WB_PICK, 32'h0000_0000);
    rd(`PTC_A_WB_FACTOR, 32'h0000_0100);
    $display("end of select test");
  endtask
  task automatic t_stream;
    logic low;
    wr(`PTC_A_GAIN, 32'h0000_0180);
    wr(`PTC_A_DARK, 32'h0000_0100);
    stall <= 1'b1;
    for (int k = 0; k < 20; k++) send(12'(k * 211), 2'(k % 2), k == 19);
    low = 1'b0;
    repeat (40) begin
      @(posedge clk);
      low = low | !pix_in_ready;
    end
    chk(low, 1'b1);
    stall <= 1'b0;
    drain(20);
    for (int k = 0; k < 20; k++) begin
      chk(i_far.got_q.pop_front(),
          {k == 19, 2'(k % 2), lvl(k * 211, 256, k % 2 ? 512 : 384, 256)});
    end
    $display("end of stream test");
  endtask
  task automatic t_table;
    wr(`PTC_A_GAIN, 32'h0000_0100);
    wr(`PTC_A_DARK, 32'h0000_0000);
    wr(`PTC_A_TBL_PICK, 32'h0000_0000);
    wr(`PTC_A_TBL_PTR, 32'h0000_0005);
    wr(`PTC_A_TBL_LEVEL, 32'h0000_0155);
    wr(`PTC_A_TBL_PTR, 32'h0000_03FF);
    wr(`PTC_A_TBL_LEVEL, 32'h0000_0007);
    rd(`PTC_A_TBL_LEVEL, 32'h0000_0007);
    wr(`PTC_A_TBL_PTR, 32'h0000_0005);
    rd(`PTC_A_TBL_PTR, 32'h0000_0005);
    rd(`PTC_A_TBL_LEVEL, 32'h0000_0155);
    send(12'h015, 2'h0, 1'b0);
    drain(1);
    chk(i_far.got_q.pop_front(), 13'h0005);
    wr(`PTC_A_TBL_ON, 32'h0000_0001);
    send(12'h015, 2'h0, 1'b0);
    drain(1);
    chk(i_far.got_q.pop_front(), 13'h0155);
    wr(`PTC_A_GAMMA, 32'h0000_0200);
    rd(`PTC_A_GAMMA, 32'h0000_0100);
    wr(`PTC_A_TBL_STORE, 32'h0000_0001);
    wait_idle;
    wr(`PTC_A_TBL_PTR, 32'h0000_0005);
    wr(`PTC_A_TBL_LEVEL, 32'h0000_0000);
    wr(`PTC_A_TBL_RECALL, 32'h0000_0001);
    wait_idle;
    wr(`PTC_A_TBL_PTR, 32'h0000_0005);
    rd(`PTC_A_TBL_LEVEL, 32'h0000_0155);
    wr(`PTC_A_TBL_PICK, 32'h0000_0001);
    rd(`PTC_A_TBL_ON, 32'h0000_0000);
    wr(`PTC_A_TBL_PICK, 32'h0000_0000);
    wr(`PTC_A_TBL_ON, 32'h0000_0000);
    $display("end of table test");
  endtask
  task automatic t_gamma;
    logic [31:0] r;
    logic e;
    wr(`PTC_A_GAMMA, 32'h0000_0200);
    wait_idle;
    rd(`PTC_A_GAMMA, 32'h0000_0200);
    wr(`PTC_A_TBL_PTR, 32'h0000_0005);
    apb(1'b0, `PTC_A_TBL_LEVEL, 32'h0000_0000, r, e);
    chk(r !== 32'h0000_0155, 1'b1);
    $display("end of gamma test");
  endtask
  task automatic t_once;
    logic [31:0] r;
    logic e;
    wr(`PTC_A_AWB_MODE, 32'h0000_0001);
    rd(`PTC_A_AWB_MODE, 32'h0000_0001);
    for (int f = 0; f < 70; f++) begin
      send(12'd400, 2'h0, 1'b0);
      send(12'd2000, 2'h1, 1'b0);
      send(12'd2000, 2'h2, 1'b1);
    end
    drain(210);
    i_far.got_q.delete();
    rd(`PTC_A_AWB_MODE, 32'h0000_0000);
    apb(1'b0, `PTC_A_WB_FACTOR, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0204);
    $display("end of auto balance test");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      $display("[ERR] %0t run took too long", $time);
      final_report;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_pick;
    t_stream;
    t_table;
    t_gamma;
    t_once;
    final_report;
  end
endmodule
bind ptc_core ptc_core_props i_props (.*);

// ==== verification/ptc_far_side.sv ====
// sensor source and packetiser sink model
module ptc_far_side (
  input wire logic clk,
  input wire logic reset,
  input wire logic stall,
  output logic pix_in_valid,
  input wire logic pix_in_ready,
  output logic [11:0] pix_in_level,
  output logic [1:0] pix_in_colour,
  output logic pix_in_last,
  input wire logic pix_out_valid,
  output logic pix_out_ready,
  input wire logic [9:0] pix_out_level,
  input wire logic [1:0] pix_out_colour,
  input wire logic pix_out_last
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // source queue and sink capture
  // ****************************************
  logic [14:0] src_q[$];
  logic [12:0] got_q[$];
  initial begin
    pix_in_valid = 1'b0;
    pix_in_level = 12'h000;
    pix_in_colour = 2'h0;
    pix_in_last = 1'b0;
    pix_out_ready = 1'b0;
  end
  always @(posedge clk) begin
    pix_out_ready <= !stall;
    if (!reset && pix_out_valid && pix_out_ready) begin
      got_q.push_back({pix_out_last, pix_out_colour, pix_out_level});
    end
    if (!pix_in_valid || pix_in_ready) begin
      if (!reset && src_q.size() > 0) begin
        {pix_in_last, pix_in_colour, pix_in_level} <= src_q.pop_front();
        pix_in_valid <= 1'b1;
      end else begin
        // idle lines toggle so stale data never looks valid
        pix_in_valid <= 1'b0;
        pix_in_level <= ~pix_in_level;
        pix_in_colour <= ~pix_in_colour;
        pix_in_last <= ~pix_in_last;
      end
    end
  end
endmodule
